// *** logic/unbt_trip.sv ***
// Negative sequence unbalance trip element with AXI4-Lite settings and interrupt.
// Assumes phasors from a same-clock front end and a same-clock protection reset pulse.
`timescale 1ns/1ps
`default_nettype none
module unbt_trip
#(
    parameter int STEP_CYCLES = unbt_pkg::STEP_CYCLES_DEF
)
(
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire unbt_pkg::unbt_phases_s phases,
    input  wire logic                   protReset,
    output var  logic                   trip,
    output var  logic                   irq,
    input  wire logic                   s_axi_awvalid,
    output var  logic                   s_axi_awready,
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_wvalid,
    output var  logic                   s_axi_wready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    output var  logic                   s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    output var  logic [1:0]             s_axi_bresp,
    input  wire logic                   s_axi_arvalid,
    output var  logic                   s_axi_arready,
    input  wire logic [7:0]             s_axi_araddr,
    output var  logic                   s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output var  logic [31:0]            s_axi_rdata,
    output var  logic [1:0]             s_axi_rresp
);
    import unbt_pkg::*;

    // Settings, each instance holds its own copy
    logic [4:0]        ctrlQ;
    logic [15:0]       floorQ;
    logic [6:0]        ratioQ;
    logic [15:0]       fixedQ;
    logic [15:0]       capQ;
    logic [15:0]       coolQ;
    logic [15:0]       flaQ;
    logic [IRQ_W-1:0]  maskQ;
    logic [IRQ_W-1:0]  irqStatQ;
    logic              swResetQ;

    // Bus state
    logic              awHeldQ;
    logic [7:0]        awAddrQ;
    logic              wHeldQ;
    logic [31:0]       wDataQ;
    logic [3:0]        wStrbQ;

    // Element state
    logic [31:0]       stepCntQ;
    logic [15:0]       timerQ;
    logic [59:0]       thetaQ;
    logic              tripQ;
    logic              pickupQ;
    unbt_div_e         divStateQ;
    logic [5:0]        divCntQ;
    logic [16:0]       remQ;
    logic [59:0]       quoQ;

    unbt_seq_s         seq;

    unbt_seq u_seq
    (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .phases  (phases),
        .reverse (ctrlQ[CTRL_REVERSE]),
        .seqOut  (seq)
    );

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        merge = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction : merge

    // Floor in per-unit of In, or scaled by full-load current
    wire logic [31:0] floorRelProd = floorQ * flaQ;
    wire logic [15:0] floorEff     = ctrlQ[CTRL_FLOORREL] ? floorRelProd[PU_SHIFT +: 16] : floorQ;
    wire logic [35:0] floorSq      = 36'(floorEff * floorEff);
    wire logic        overFloor    = seq.negSq > floorSq;

    wire logic [51:0] negScaled    = 52'(seq.negSq * RATIO_FULL_SQ);
    wire logic [51:0] posScaled    = 52'(seq.posSq * (ratioQ * ratioQ));
    wire logic        ratioOk      = !ctrlQ[CTRL_RATIO_EN] || (negScaled > posScaled);
    wire logic        pickupNow    = ctrlQ[CTRL_ENABLE] && overFloor && ratioOk;

    wire logic        stepTick     = stepCntQ == 32'(STEP_CYCLES - 1);
    wire logic        doReset      = protReset || swResetQ;

    // Thermal maximum: capability seconds times steps per second at 1.0 In squared
    wire logic [59:0] thetaMax     = 60'(capQ) * 60'(STEPS_PER_SEC) << (2 * PU_SHIFT);
    wire logic [59:0] heatStep     = 60'(seq.negSq - floorSq);
    wire logic [59:0] thetaHeat    = thetaQ + heatStep;
    wire logic [15:0] coolDiv      = (coolQ == 16'h0000) ? 16'h0001 : coolQ;
    wire logic [59:0] thetaCool    = thetaQ - quoQ;
    wire logic [67:0] coolScaled   = 68'(thetaCool) * 68'(COOL_END_DIV);
    wire logic        coolEnd      = coolScaled < 68'(thetaMax);

    // Serial divider step
    wire logic [16:0] remShift     = {remQ[15:0], quoQ[59]};
    wire logic        remGe        = remShift >= {1'b0, coolDiv};
    wire logic [16:0] remNext      = remGe ? remShift - {1'b0, coolDiv} : remShift;
    wire logic        divDone      = (divStateQ == DIV_RUN) && (divCntQ == 6'h00);

    // Trip decision per curve
    wire logic        fixedDone    = timerQ >= fixedQ;
    wire logic        thermalDone  = thetaQ > thetaMax;
    wire logic        tripNow      = pickupNow && ((unbt_curve_e'(ctrlQ[CTRL_CURVE]) == CURVE_DEPENDENT)
                                                   ? thermalDone : fixedDone);
    wire logic        tripD        = tripNow && !doReset;

    // Register bus decode
    wire logic        wrFire       = awHeldQ && wHeldQ;
    wire logic        arFire       = s_axi_arvalid && s_axi_arready;
    wire logic        rdIrqStat    = arFire && (s_axi_araddr == REG_IRQSTAT);
    wire logic [31:0] wrCtrl       = merge({23'h0, swResetQ, 3'h0, ctrlQ}, wDataQ, wStrbQ);
    wire logic [IRQ_W-1:0] irqEvt  = {pickupNow && !pickupQ, tripD && !tripQ};

    assign s_axi_awready = !awHeldQ && !s_axi_bvalid;
    assign s_axi_wready  = !wHeldQ && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign trip          = tripQ;
    assign irq           = |(irqStatQ & maskQ);

    // Readable registers; thermal energy deliberately absent
    logic [31:0] rdMux;
    logic        rdHit;
    always_comb
    begin
        rdHit = 1'b1;
        case (s_axi_araddr)
            REG_CTRL:    rdMux = {27'h0, ctrlQ};
            REG_FLOOR:   rdMux = {16'h0, floorQ};
            REG_RATIO:   rdMux = {25'h0, ratioQ};
            REG_FIXED:   rdMux = {16'h0, fixedQ};
            REG_CAP:     rdMux = {16'h0, capQ};
            REG_COOL:    rdMux = {16'h0, coolQ};
            REG_FLA:     rdMux = {16'h0, flaQ};
            REG_STATE:   rdMux = {29'h0, overFloor, pickupQ, tripQ};
            REG_IRQSTAT: rdMux = {30'h0, irqStatQ};
            REG_IRQMASK: rdMux = {30'h0, maskQ};
            default:
            begin
                rdMux = 32'h0;
                rdHit = 1'b0;
            end
        endcase
    end

    // Write address and data capture
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            awHeldQ <= 1'b0;
            awAddrQ <= 8'h00;
            wHeldQ  <= 1'b0;
            wDataQ  <= 32'h0;
            wStrbQ  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeldQ <= 1'b1;
                awAddrQ <= s_axi_awaddr;
            end
            else if (wrFire)
            begin
                awHeldQ <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeldQ <= 1'b1;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            else if (wrFire)
            begin
                wHeldQ <= 1'b0;
            end
        end
    end

    // Write and read responses
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end
        else
        begin
            if (wrFire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddrQ <= REG_IRQMASK && awAddrQ[1:0] == 2'b00) ? RESP_OKAY : RESP_DECERR;
            end
            else if (s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
            if (arFire)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdMux;
                s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_DECERR;
            end
            else if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Setting registers
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrlQ    <= CTRL_RST;
            floorQ   <= FLOOR_RST;
            ratioQ   <= RATIO_RST;
            fixedQ   <= FIXED_RST;
            capQ     <= CAP_RST;
            coolQ    <= COOL_RST;
            flaQ     <= FLA_RST;
            maskQ    <= MASK_RST;
            swResetQ <= 1'b0;
        end
        else
        begin
            swResetQ <= wrFire && (awAddrQ == REG_CTRL) && wrCtrl[CTRL_PROTRST];
            if (wrFire)
            begin
                case (awAddrQ)
                    REG_CTRL:    ctrlQ  <= wrCtrl[4:0];
                    REG_FLOOR:   floorQ <= merge({16'h0, floorQ}, wDataQ, wStrbQ) [15:0];
                    REG_RATIO:   ratioQ <= merge({25'h0, ratioQ}, wDataQ, wStrbQ) [6:0];
                    REG_FIXED:   fixedQ <= merge({16'h0, fixedQ}, wDataQ, wStrbQ) [15:0];
                    REG_CAP:     capQ   <= merge({16'h0, capQ}, wDataQ, wStrbQ) [15:0];
                    REG_COOL:    coolQ  <= merge({16'h0, coolQ}, wDataQ, wStrbQ) [15:0];
                    REG_FLA:     flaQ   <= merge({16'h0, flaQ}, wDataQ, wStrbQ) [15:0];
                    REG_IRQMASK: maskQ  <= merge({30'h0, maskQ}, wDataQ, wStrbQ) [IRQ_W-1:0];
                    default:     ;
                endcase
            end
        end
    end

    // Sticky events, cleared by reading, a new event wins
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irqStatQ <= '0;
        end
        else
        begin
            irqStatQ <= (rdIrqStat ? '0 : irqStatQ) | irqEvt;
        end
    end

    // Step timebase and fixed delay timer
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stepCntQ <= 32'h0;
            timerQ   <= 16'h0;
            tripQ    <= 1'b0;
            pickupQ  <= 1'b0;
        end
        else
        begin
            stepCntQ <= stepTick ? 32'h0 : stepCntQ + 32'h1;
            pickupQ  <= pickupNow && !doReset;
            tripQ    <= tripD;
            if (doReset || !pickupNow)
            begin
                timerQ <= 16'h0;
            end
            else if (stepTick && !fixedDone)
            begin
                timerQ <= timerQ + 16'h1;
            end
        end
    end

    // Thermal energy: heating integration, cooling decay by serial division
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            thetaQ    <= 60'h0;
            divStateQ <= DIV_IDLE;
            divCntQ   <= 6'h00;
            remQ      <= 17'h0;
            quoQ      <= 60'h0;
        end
        else if (doReset)
        begin
            thetaQ    <= 60'h0;
            divStateQ <= DIV_IDLE;
        end
        else
        begin
            case (divStateQ)
                DIV_IDLE:
                begin
                    if (stepTick && overFloor)
                    begin
                        thetaQ <= thetaHeat;
                    end
                    else if (stepTick && thetaQ != 60'h0)
                    begin
                        divStateQ <= DIV_RUN;
                        divCntQ   <= 6'd60;
                        remQ      <= 17'h0;
                        quoQ      <= thetaQ;
                    end
                end
                DIV_RUN:
                begin
                    if (divDone)
                    begin
                        divStateQ <= DIV_IDLE;
                        thetaQ    <= coolEnd ? 60'h0 : thetaCool;
                    end
                    else
                    begin
                        divCntQ <= divCntQ - 6'h01;
                        remQ    <= remNext;
                        quoQ    <= {quoQ[58:0], remGe};
                    end
                end
                default:
                begin
                    divStateQ <= DIV_IDLE;
                end
            endcase
        end
    end

endmodule : unbt_trip
`default_nettype wire

// *** shared/unbt_pkg.sv ***
// Shared constants and types of the negative sequence unbalance trip element.
// Assumes a single 100 MHz processing clock and per-unit currents with 1.0 In = 4096.
package unbt_pkg;

    // Clock and processing step
    localparam int CLK_PERIOD_NS   = 10;
    localparam int STEP_TIME_US    = 1000;
    localparam int STEP_CYCLES_DEF = (STEP_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int STEPS_PER_SEC   = 1000000 / STEP_TIME_US;

    // Current scaling: 1.0 In is 2**PU_SHIFT counts
    localparam int PU_SHIFT        = 12;
    localparam int RATIO_FULL_SQ   = 10000;
    localparam int COOL_END_DIV    = 100;

    // Sequence arithmetic constants, in units of 2**15
    localparam logic signed [17:0] COEF_HALF  = 18'sh04000;
    localparam logic signed [17:0] COEF_SQ3H  = 18'sh06eda;
    localparam logic signed [17:0] COEF_THIRD = 18'sh02aab;
    localparam int                 COEF_SHIFT = 30;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_FLOOR   = 8'h04;
    localparam logic [7:0] REG_RATIO   = 8'h08;
    localparam logic [7:0] REG_FIXED   = 8'h0c;
    localparam logic [7:0] REG_CAP     = 8'h10;
    localparam logic [7:0] REG_COOL    = 8'h14;
    localparam logic [7:0] REG_FLA     = 8'h18;
    localparam logic [7:0] REG_STATE   = 8'h1c;
    localparam logic [7:0] REG_IRQSTAT = 8'h20;
    localparam logic [7:0] REG_IRQMASK = 8'h24;

    // Control field positions
    localparam int CTRL_ENABLE   = 0;
    localparam int CTRL_CURVE    = 1;
    localparam int CTRL_RATIO_EN = 2;
    localparam int CTRL_FLOORREL = 3;
    localparam int CTRL_REVERSE  = 4;
    localparam int CTRL_PROTRST  = 8;

    // State and interrupt bit positions
    localparam int ST_TRIP    = 0;
    localparam int ST_PICKUP  = 1;
    localparam int ST_HEATING = 2;
    localparam int IRQ_W      = 2;

    // Reset values
    localparam logic [4:0]  CTRL_RST  = 5'h00;
    localparam logic [15:0] FLOOR_RST = 16'h0199;
    localparam logic [6:0]  RATIO_RST = 7'h0a;
    localparam logic [15:0] FIXED_RST = 16'h03e8;
    localparam logic [15:0] CAP_RST   = 16'h000a;
    localparam logic [15:0] COOL_RST  = 16'h2710;
    localparam logic [15:0] FLA_RST   = 16'h1000;
    localparam logic [1:0]  MASK_RST  = 2'h0;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef enum logic [0:0] {
        CURVE_FIXED     = 1'b0,
        CURVE_DEPENDENT = 1'b1
    } unbt_curve_e;

    typedef enum logic [0:0] {
        DIV_IDLE = 1'b0,
        DIV_RUN  = 1'b1
    } unbt_div_e;

    typedef struct packed {
        logic signed [15:0] re;
        logic signed [15:0] im;
    } unbt_phasor_s;

    typedef struct packed {
        unbt_phasor_s l1;
        unbt_phasor_s l2;
        unbt_phasor_s l3;
    } unbt_phases_s;

    typedef struct packed {
        logic [35:0] posSq;
        logic [35:0] negSq;
    } unbt_seq_s;

endpackage : unbt_pkg

// *** logic/unbt_seq.sv ***
// Symmetrical component calculator: squared magnitudes of positive and negative sequence.
// Assumes phase phasors from the measurement front end on the same clock.
`timescale 1ns/1ps
`default_nettype none
module unbt_seq
(
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    input  wire unbt_pkg::unbt_phases_s phases,
    input  wire logic                  reverse,
    output var  unbt_pkg::unbt_seq_s    seqOut
);
    import unbt_pkg::*;

    // Rotation by a (sgn=0) or a squared (sgn=1), result scaled by 2**15
    function automatic logic signed [35:0] rotRe(input unbt_phasor_s p, input logic sgn);
        logic signed [35:0] hr;
        logic signed [35:0] si;
        hr = 36'(p.re * COEF_HALF);
        si = 36'(p.im * COEF_SQ3H);
        rotRe = sgn ? (si - hr) : (-hr - si);
    endfunction : rotRe

    function automatic logic signed [35:0] rotIm(input unbt_phasor_s p, input logic sgn);
        logic signed [35:0] hi;
        logic signed [35:0] sr;
        hi = 36'(p.im * COEF_HALF);
        sr = 36'(p.re * COEF_SQ3H);
        rotIm = sgn ? (-sr - hi) : (sr - hi);
    endfunction : rotIm

    function automatic logic [35:0] magSq(input logic signed [35:0] re, input logic signed [35:0] im);
        logic signed [53:0] r;
        logic signed [53:0] i;
        r = 54'(re * COEF_THIRD) >>> COEF_SHIFT;
        i = 54'(im * COEF_THIRD) >>> COEF_SHIFT;
        magSq = 36'(r * r + i * i);
    endfunction : magSq

    wire logic signed [35:0] baseRe = 36'(phases.l1.re) <<< 15;
    wire logic signed [35:0] baseIm = 36'(phases.l1.im) <<< 15;

    // Forward-rotation sequences
    wire logic [35:0] fwdPosSq = magSq(baseRe + rotRe(phases.l2, 1'b0) + rotRe(phases.l3, 1'b1),
                                       baseIm + rotIm(phases.l2, 1'b0) + rotIm(phases.l3, 1'b1));
    wire logic [35:0] fwdNegSq = magSq(baseRe + rotRe(phases.l2, 1'b1) + rotRe(phases.l3, 1'b0),
                                       baseIm + rotIm(phases.l2, 1'b1) + rotIm(phases.l3, 1'b0));

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            seqOut <= '0;
        end
        else
        begin
            seqOut.posSq <= reverse ? fwdNegSq : fwdPosSq;
            seqOut.negSq <= reverse ? fwdPosSq : fwdNegSq;
        end
    end

endmodule : unbt_seq
`default_nettype wire

// *** test/unbt_trip_asserts.sv ***
// Port checks for the unbalance trip element.
// Assumes binding onto unbt_trip, one clock.
`timescale 1ns/1ps
`default_nettype none
module unbt_trip_asserts
#(
    parameter int STEP_CYCLES = 100
)
(
    input wire logic                   ref_clk,
    input wire logic                   rstn,
    input wire unbt_pkg::unbt_phases_s phases,
    input wire logic                   protReset,
    input wire logic                   trip,
    input wire logic                   irq,
    input wire logic                   s_axi_awvalid,
    input wire logic                   s_axi_awready,
    input wire logic [7:0]             s_axi_awaddr,
    input wire logic                   s_axi_wvalid,
    input wire logic                   s_axi_wready,
    input wire logic [31:0]            s_axi_wdata,
    input wire logic [3:0]             s_axi_wstrb,
    input wire logic                   s_axi_bvalid,
    input wire logic                   s_axi_bready,
    input wire logic [1:0]             s_axi_bresp,
    input wire logic                   s_axi_arvalid,
    input wire logic                   s_axi_arready,
    input wire logic [7:0]             s_axi_araddr,
    input wire logic                   s_axi_rvalid,
    input wire logic                   s_axi_rready,
    input wire logic [31:0]            s_axi_rdata,
    input wire logic [1:0]             s_axi_rresp
);
    import unbt_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence both_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence resp_late_s;
        ##2 s_axi_bvalid;
    endsequence
    prot_clear_a: assert property (protReset |=> !trip) else $error("trip kept after reset");
    no_current_a: assert property ((phases == '0) [*3] |-> !trip) else $error("trip without current");
    trip_rise_a: assert property ($rose(trip) |-> $past(phases, 2) != '0) else $error("trip rose early");
    write_resp_a: assert property (both_taken_s |-> resp_late_s) else $error("write response late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
    ch_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write reaccepted");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read reaccepted");
    decerr_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h27
        |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
endmodule : unbt_trip_asserts
bind unbt_trip unbt_trip_asserts #(.STEP_CYCLES(STEP_CYCLES)) chk_u (.*);
`default_nettype wire

// *** test/unbt_front.sv ***
// Current front end model: positive plus negative sequence phasor set.
// Assumes magnitudes at 1.0 In = 4096 on the element clock.
`timescale 1ns/1ps
`default_nettype none
module unbt_front
(
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic [15:0]            balMag,
    input  wire logic [15:0]            negMag,
    output var  unbt_pkg::unbt_phases_s phases
);
    import unbt_pkg::*;
    logic signed [31:0] sumMag;
    logic signed [31:0] halfRe;
    logic signed [31:0] sinIm;
    assign sumMag = 32'(balMag) + 32'(negMag);
    assign halfRe = -(sumMag >>> 1);
    assign sinIm  = ((32'(negMag) - 32'(balMag)) * 7094) >>> 13;
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            phases <= '0;
        else
            phases <= {16'(sumMag), 16'h0, 16'(halfRe), 16'(sinIm), 16'(halfRe), 16'(-sinIm)};
    end
endmodule : unbt_front
`default_nettype wire

// *** test/unbt_trip_tb.sv ***
// Self-checking bench for the unbalance trip element.
// Assumes the front end model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module unbt_trip_tb;
    import unbt_pkg::*;
    localparam int STEP = 100;
    logic         ref_clk, rstn, protReset, trip, irq;
    logic [15:0]  balMag, negMag;
    unbt_phases_s phases;
    logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic         s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]   s_axi_awaddr, s_axi_araddr;
    logic [31:0]  s_axi_wdata, s_axi_rdata, rdVal;
    logic [3:0]   s_axi_wstrb;
    logic [1:0]   s_axi_bresp, s_axi_rresp, rsp;
    int           failures, num_checks, tripAt;
    unbt_front front_u (.ref_clk(ref_clk), .rstn(rstn), .balMag(balMag), .negMag(negMag), .phases(phases));
    unbt_trip #(.STEP_CYCLES(STEP)) dut_u (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, done;
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        done = 1'b0;
        while (!done)
        begin
            @(negedge ref_clk);
            {aw, w} = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready};
            {done, rsp} = {s_axi_bvalid, s_axi_bresp};
            @(posedge ref_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        logic ar, done;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        done = 1'b0;
        while (!done)
        begin
            @(negedge ref_clk);
            ar = s_axi_arvalid && s_axi_arready;
            {done, rdVal, rsp} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge ref_clk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk(rdVal, exp);
        @(posedge ref_clk);
    endtask : rchk
    task automatic wait_trip(input int lim);
        tripAt = 0;
        while (trip !== 1'b1 && tripAt < lim)
        begin
            @(negedge ref_clk);
            tripAt++;
        end
    endtask : wait_trip
    task automatic t_regs();
        logic [7:0]  addrs [9] = '{REG_CTRL, REG_FLOOR, REG_RATIO, REG_FIXED, REG_CAP, REG_COOL, REG_FLA, REG_IRQMASK, 8'h40};
        logic [31:0] vals [9] = '{32'(CTRL_RST), 32'(FLOOR_RST), 32'(RATIO_RST), 32'(FIXED_RST), 32'(CAP_RST),
                                  32'(COOL_RST), 32'(FLA_RST), 32'(MASK_RST), 32'h0};
        for (int i = 0; i < 9; i++)
        begin
            rchk(addrs[i], vals[i]);
            chk(32'(rsp), (i == 8) ? 32'(RESP_DECERR) : 32'(RESP_OKAY));
        end
        wr(8'h40, 32'h1);
        chk(32'(rsp), 32'(RESP_DECERR));
    endtask : t_regs
    task automatic t_fixed();
        wr(REG_FIXED, 32'h5);
        wr(REG_IRQMASK, 32'h3);
        wr(REG_CTRL, 32'h1);
        {balMag, negMag} <= {16'h1000, 16'h0800};
        wait_trip(2000);
        chk(32'(tripAt >= 350 && tripAt <= 700), 32'h1);
        chk(32'(irq), 32'h1);
        @(posedge ref_clk);
        rchk(REG_IRQSTAT, 32'h3);
        @(negedge ref_clk);
        chk(32'(irq), 32'h0);
        @(posedge ref_clk);
        protReset <= 1'b1;
        @(posedge ref_clk);
        protReset <= 1'b0;
        @(negedge ref_clk);
        chk(32'(trip), 32'h0);
        @(posedge ref_clk);
        {balMag, negMag} <= 32'h0;
    endtask : t_fixed
    task automatic t_ratio();
        wr(REG_RATIO, 32'd30);
        wr(REG_CTRL, 32'h5);
        {balMag, negMag} <= {16'h1000, 16'h0333};
        repeat (8) @(posedge ref_clk);
        rchk(REG_STATE, 32'h4);
        wr(REG_RATIO, 32'd10);
        rchk(REG_STATE, 32'h6);
        wr(REG_FLA, 32'h4000);
        wr(REG_CTRL, 32'hd);
        rchk(REG_STATE, 32'h0);
        negMag <= 16'h0;
        wr(REG_CTRL, 32'h9);
        rchk(REG_STATE, 32'h0);
        wr(REG_CTRL, 32'h19);
        rchk(REG_STATE, 32'h6);
        balMag <= 16'h0;
        wr(REG_CTRL, 32'h0);
    endtask : t_ratio
    task automatic t_dep();
        wr(REG_FLOOR, 32'h0);
        wr(REG_CAP, 32'h1);
        wr(REG_CTRL, 32'h102);
        negMag <= 16'h2000;
        wr(REG_CTRL, 32'h3);
        wait_trip(30000);
        chk(32'(tripAt >= 24500 && tripAt <= 25600), 32'h1);
        @(posedge ref_clk);
        wr(REG_CTRL, 32'h102);
        @(negedge ref_clk);
        chk(32'(trip), 32'h0);
        repeat (200 * STEP) @(posedge ref_clk);
        chk(32'(trip), 32'h0);
        wr(REG_CTRL, 32'h3);
        wait_trip(10000);
        chk(32'(tripAt >= 4500 && tripAt <= 5800), 32'h1);
        // Ten cooling steps at tau of ten leave about 0.35 of maximum
        @(posedge ref_clk);
        wr(REG_COOL, 32'd10);
        negMag <= 16'h0;
        repeat (1000) @(posedge ref_clk);
        negMag <= 16'h2000;
        wait_trip(20000);
        chk(32'(tripAt >= 15800 && tripAt <= 16800), 32'h1);
    endtask : t_dep
    task automatic final_report();
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        #800000;
        failures++;
        final_report();
    end
    initial
    begin
        {rstn, protReset, balMag, negMag, s_axi_wstrb} = {34'h0, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_fixed();
        t_ratio();
        t_dep();
        final_report();
    end
endmodule : unbt_trip_tb
`default_nettype wire
